// [common/lcrt_pkg.sv]
// Constants, field positions and carriers for the text scan control block.
// Assumes all users run on one clock with an active-low async reset.
//
// What this block does
// - Top text row starts at preset row.
// - Double scan halves the row counter rate.
// - Line compare is a 10-bit split value.
// - Compare line restarts address counter at zero.
// - Above compare line, fetch from start address.
// - Vertical blank start is a 10-bit split value.
// - Blanking begins on line equal to start.
// - Max scan field is row height minus one.
// - Cursor-off bit hides cursor; graphics ignores it.
// - Cursor starts on selected box row.
// - Cursor ends on selected box row.
// - Cursor skew delays by 0..3 char clocks.
// - Start address is high and low bytes.
// - Cursor sits at 16-bit location offset.
// - Vertical sync start is a 10-bit split value.
// - Sync begins on line equal to start.
package lcrt_pkg;

  localparam logic [7:0] VOF_IDX = 8'h07;
  localparam logic [7:0] PRS_IDX = 8'h08;
  localparam logic [7:0] MSL_IDX = 8'h09;
  localparam logic [7:0] CSR_IDX = 8'h0A;
  localparam logic [7:0] CER_IDX = 8'h0B;
  localparam logic [7:0] SAH_IDX = 8'h0C;
  localparam logic [7:0] SAL_IDX = 8'h0D;
  localparam logic [7:0] CLH_IDX = 8'h0E;
  localparam logic [7:0] CLL_IDX = 8'h0F;
  localparam logic [7:0] VSS_IDX = 8'h10;
  localparam logic [7:0] VSE_IDX = 8'h11;
  localparam logic [7:0] VBS_IDX = 8'h15;
  localparam logic [7:0] LCL_IDX = 8'h18;

  localparam logic [7:0] REG_RST   = 8'h00;
  localparam logic [7:0] PRS_WMASK = 8'h7F;
  localparam logic [7:0] CSR_WMASK = 8'h3F;
  localparam logic [7:0] CER_WMASK = 8'h7F;

  localparam int MSL_DSCAN = 7;
  localparam int MSL_LC9   = 6;
  localparam int MSL_VB9   = 5;
  localparam int VOF_VS9   = 7;
  localparam int VOF_LC8   = 4;
  localparam int VOF_VB8   = 3;
  localparam int VOF_VS8   = 2;
  localparam int CSR_OFF   = 5;
  localparam int CER_SKW   = 5;

  typedef struct packed {
    logic       wr;
    logic [7:0] idx;
    logic [7:0] wdata;
  } lcrt_bus_s;

  typedef struct packed {
    logic line_start;
    logic frame_start;
    logic char_tick;
  } lcrt_tick_s;

endpackage

// [src/lcrt_row_scan.sv]
// Row scan and scan line counters.
// Assumes line_start pulses once per scan line; frame_start comes with
// the line_start of scan line 0.
`timescale 1ns/10ps
module lcrt_row_scan
  import lcrt_pkg::*;
#(
  parameter int ROW_W  = 5,
  parameter int LINE_W = 10
)
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              line_start,
  input  wire logic              frame_start,
  input  wire logic              double_scan,
  input  wire logic [ROW_W-1:0]  max_row,
  input  wire logic [ROW_W-1:0]  preset_row,
  output logic      [ROW_W-1:0]  row_scan_reg,
  output logic      [LINE_W-1:0] scan_line_reg,
  output logic                   row_wrap_reg
);

  logic half_reg;
  logic step;

  assign step = !double_scan || half_reg;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      row_scan_reg  <= '0;
      scan_line_reg <= '0;
      row_wrap_reg  <= 1'b0;
      half_reg      <= 1'b0;
    end
    else
    begin
      row_wrap_reg <= 1'b0;
      if (frame_start)
      begin
        row_scan_reg  <= preset_row;
        scan_line_reg <= '0;
        half_reg      <= 1'b0;
      end
      else if (line_start)
      begin
        scan_line_reg <= scan_line_reg + 1'b1;
        half_reg      <= double_scan ? !half_reg : 1'b0;
        if (step)
        begin
          if (row_scan_reg == max_row)
          begin
            row_scan_reg <= '0;
            row_wrap_reg <= 1'b1;
          end
          else
            row_scan_reg <= row_scan_reg + 1'b1;
        end
      end
    end
  end

  property p_preset;
    @(posedge clk) disable iff (!arst_n)
    frame_start |=> row_scan_reg == $past(preset_row);
  endproperty
  a_preset: assert property (p_preset)
    else $error("Top row did not start at preset row");

  property p_height;
    @(posedge clk) disable iff (!arst_n)
    line_start && !frame_start && !double_scan && row_scan_reg == max_row
    |=> row_scan_reg == '0 && row_wrap_reg;
  endproperty
  a_height: assert property (p_height)
    else $error("Row did not wrap at max scan line");

  property p_dscan;
    @(posedge clk) disable iff (!arst_n)
    line_start && !frame_start && double_scan && !half_reg
    |=> $stable(row_scan_reg) && half_reg;
  endproperty
  a_dscan: assert property (p_dscan)
    else $error("Row advanced on first half of double scan");

endmodule

// [src/lcrt_cursor_skew.sv]
// Cursor delay line in character clocks.
// Assumes char_tick is a one-cycle pulse per character clock.
`timescale 1ns/10ps
module lcrt_cursor_skew
  import lcrt_pkg::*;
#(
  parameter int DEPTH = 3
)
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       char_tick,
  input  wire logic [1:0] skew,
  input  wire logic       cur_in,
  output logic            cur_out_reg
);

  logic [DEPTH-1:0] dly_reg;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      dly_reg <= '0;
    else if (char_tick)
      dly_reg <= {dly_reg[DEPTH-2:0], cur_in};
  end

  // Skew 0 bypasses the line so the cursor is not late by a whole tick
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cur_out_reg <= 1'b0;
    else if (skew == 2'b00)
      cur_out_reg <= cur_in;
    else
      cur_out_reg <= dly_reg[skew - 2'h1];
  end

  property p_noskew;
    @(posedge clk) disable iff (!arst_n)
    skew == 2'b00 |=> cur_out_reg == $past(cur_in);
  endproperty
  a_noskew: assert property (p_noskew)
    else $error("Zero skew did not pass cursor straight");

  property p_skew1;
    @(posedge clk) disable iff (!arst_n)
    skew == 2'b01 |=> cur_out_reg == $past(dly_reg[0]);
  endproperty
  a_skew1: assert property (p_skew1)
    else $error("Skew of one used wrong tap");

endmodule

// [src/lcrt_scan_ctrl.sv]
// Text scan control: indexed registers, address counter, split screen,
// vertical blank and sync starts, text cursor.
// Assumes tick strobes come from horizontal timing on the same clock.
`timescale 1ns/10ps
module lcrt_scan_ctrl
  import lcrt_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int LINE_W = 10,
  parameter int ROW_W  = 5
)
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire lcrt_bus_s         bus,
  input  wire lcrt_tick_s        tick,
  input  wire logic              text_mode,
  output logic      [7:0]        rd_data,
  output logic      [ADDR_W-1:0] mem_addr,
  output logic      [ROW_W-1:0]  row_scan,
  output logic      [LINE_W-1:0] scan_line,
  output logic                   vblank,
  output logic                   vsync,
  output logic                   cursor_on
);

  function automatic logic [9:0] cat10(
    input logic       b9,
    input logic       b8,
    input logic [7:0] lo
  );
    cat10 = {b9, b8, lo};
  endfunction

  logic [7:0] vertical_overflow_reg;
  logic [7:0] preset_row_scan_reg;
  logic [7:0] max_scan_line_reg;
  logic [7:0] cursor_start_reg;
  logic [7:0] cursor_end_reg;
  logic [7:0] start_addr_high_reg;
  logic [7:0] start_addr_low_reg;
  logic [7:0] cursor_loc_high_reg;
  logic [7:0] cursor_loc_low_reg;
  logic [7:0] vsync_start_reg;
  logic [7:0] vsync_end_reg;
  logic [7:0] vblank_start_reg;
  logic [7:0] line_compare_low_reg;

  logic [7:0]        rd_data_reg;
  logic [7:0]        rd_next;
  logic [ADDR_W-1:0] mem_addr_reg;
  logic [ADDR_W-1:0] row_base_reg;
  logic              vblank_reg;
  logic              vsync_reg;
  logic              cur_hit_reg;
  logic              line_go_reg;
  logic              frame_go_reg;
  logic              row_wrap;
  logic              cur_out;

  logic [9:0]        line_cmp;
  logic [9:0]        vb_start;
  logic [9:0]        vs_start;
  logic [ADDR_W-1:0] start_addr;
  logic [ADDR_W-1:0] cursor_loc;
  logic              cursor_en;

  assign line_cmp = cat10(max_scan_line_reg[MSL_LC9],
                          vertical_overflow_reg[VOF_LC8],
                          line_compare_low_reg);
  assign vb_start = cat10(max_scan_line_reg[MSL_VB9],
                          vertical_overflow_reg[VOF_VB8],
                          vblank_start_reg);
  assign vs_start = cat10(vertical_overflow_reg[VOF_VS9],
                          vertical_overflow_reg[VOF_VS8],
                          vsync_start_reg);
  assign start_addr = {start_addr_high_reg, start_addr_low_reg};
  assign cursor_loc = {cursor_loc_high_reg, cursor_loc_low_reg};
  assign cursor_en  = text_mode && !cursor_start_reg[CSR_OFF];

  // Register writes; reserved bits are masked on the way in
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      vertical_overflow_reg <= REG_RST;
      preset_row_scan_reg   <= REG_RST;
      max_scan_line_reg     <= REG_RST;
      cursor_start_reg      <= REG_RST;
      cursor_end_reg        <= REG_RST;
      start_addr_high_reg   <= REG_RST;
      start_addr_low_reg    <= REG_RST;
      cursor_loc_high_reg   <= REG_RST;
      cursor_loc_low_reg    <= REG_RST;
      vsync_start_reg       <= REG_RST;
      vsync_end_reg         <= REG_RST;
      vblank_start_reg      <= REG_RST;
      line_compare_low_reg  <= REG_RST;
    end
    else if (bus.wr)
    begin
      unique case (bus.idx)
        VOF_IDX: vertical_overflow_reg <= bus.wdata;
        PRS_IDX: preset_row_scan_reg   <= bus.wdata & PRS_WMASK;
        MSL_IDX: max_scan_line_reg     <= bus.wdata;
        CSR_IDX: cursor_start_reg      <= bus.wdata & CSR_WMASK;
        CER_IDX: cursor_end_reg        <= bus.wdata & CER_WMASK;
        SAH_IDX: start_addr_high_reg   <= bus.wdata;
        SAL_IDX: start_addr_low_reg    <= bus.wdata;
        CLH_IDX: cursor_loc_high_reg   <= bus.wdata;
        CLL_IDX: cursor_loc_low_reg    <= bus.wdata;
        VSS_IDX: vsync_start_reg       <= bus.wdata;
        VSE_IDX: vsync_end_reg         <= bus.wdata;
        VBS_IDX: vblank_start_reg      <= bus.wdata;
        LCL_IDX: line_compare_low_reg  <= bus.wdata;
        default: ;
      endcase
    end
  end

  // Read mux; unmapped indexes read zero
  always_comb
  begin
    unique case (bus.idx)
      VOF_IDX: rd_next = vertical_overflow_reg;
      PRS_IDX: rd_next = preset_row_scan_reg;
      MSL_IDX: rd_next = max_scan_line_reg;
      CSR_IDX: rd_next = cursor_start_reg;
      CER_IDX: rd_next = cursor_end_reg;
      SAH_IDX: rd_next = start_addr_high_reg;
      SAL_IDX: rd_next = start_addr_low_reg;
      CLH_IDX: rd_next = cursor_loc_high_reg;
      CLL_IDX: rd_next = cursor_loc_low_reg;
      VSS_IDX: rd_next = vsync_start_reg;
      VSE_IDX: rd_next = vsync_end_reg;
      VBS_IDX: rd_next = vblank_start_reg;
      LCL_IDX: rd_next = line_compare_low_reg;
      default: rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rd_data_reg <= 8'h00;
    else
      rd_data_reg <= rd_next;
  end

  lcrt_row_scan #(
    .ROW_W  (ROW_W),
    .LINE_W (LINE_W)
  ) u_row_scan (
    .clk           (clk),
    .arst_n        (arst_n),
    .line_start    (tick.line_start),
    .frame_start   (tick.frame_start),
    .double_scan   (max_scan_line_reg[MSL_DSCAN]),
    .max_row       (max_scan_line_reg[ROW_W-1:0]),
    .preset_row    (preset_row_scan_reg[ROW_W-1:0]),
    .row_scan_reg  (row_scan),
    .scan_line_reg (scan_line),
    .row_wrap_reg  (row_wrap)
  );

  // Line decisions wait one cycle so the new line number has settled
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      line_go_reg  <= 1'b0;
      frame_go_reg <= 1'b0;
    end
    else
    begin
      line_go_reg  <= tick.line_start || tick.frame_start;
      frame_go_reg <= tick.frame_start;
    end
  end

  // Address counter; compare line wins so a compare at line 0 still works
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mem_addr_reg <= '0;
      row_base_reg <= '0;
    end
    else if (line_go_reg)
    begin
      if (scan_line == line_cmp)
      begin
        mem_addr_reg <= '0;
        row_base_reg <= '0;
      end
      else if (frame_go_reg)
      begin
        mem_addr_reg <= start_addr;
        row_base_reg <= start_addr;
      end
      else if (row_wrap)
        row_base_reg <= mem_addr_reg;
      else
        mem_addr_reg <= row_base_reg;
    end
    else if (tick.char_tick)
      mem_addr_reg <= mem_addr_reg + 1'b1;
  end

  // Blank ends at frame start; its end value is held elsewhere
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      vblank_reg <= 1'b0;
    else if (line_go_reg && scan_line == vb_start)
      vblank_reg <= 1'b1;
    else if (frame_go_reg)
      vblank_reg <= 1'b0;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      vsync_reg <= 1'b0;
    else if (line_go_reg && scan_line == vs_start)
      vsync_reg <= 1'b1;
    else if (line_go_reg && scan_line[3:0] == vsync_end_reg[3:0])
      vsync_reg <= 1'b0;
    else if (frame_go_reg)
      vsync_reg <= 1'b0;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cur_hit_reg <= 1'b0;
    else
      cur_hit_reg <= cursor_en
        && mem_addr_reg == cursor_loc
        && row_scan >= cursor_start_reg[ROW_W-1:0]
        && row_scan <= cursor_end_reg[ROW_W-1:0];
  end

  lcrt_cursor_skew #(
    .DEPTH (3)
  ) u_cursor_skew (
    .clk         (clk),
    .arst_n      (arst_n),
    .char_tick   (tick.char_tick),
    .skew        (cursor_end_reg[CER_SKW+1:CER_SKW]),
    .cur_in      (cur_hit_reg),
    .cur_out_reg (cur_out)
  );

  assign rd_data   = rd_data_reg;
  assign mem_addr  = mem_addr_reg;
  assign vblank    = vblank_reg;
  assign vsync     = vsync_reg;
  assign cursor_on = cur_out;

  sequence s_cmp_line;
    line_go_reg && scan_line == line_cmp;
  endsequence

  sequence s_frame_top;
    line_go_reg && frame_go_reg && scan_line != line_cmp;
  endsequence

  property p_split;
    @(posedge clk) disable iff (!arst_n)
    s_cmp_line |=> mem_addr_reg == '0 && row_base_reg == '0;
  endproperty
  a_split: assert property (p_split)
    else $error("Address counter not cleared on compare line");

  property p_top;
    @(posedge clk) disable iff (!arst_n)
    s_frame_top |=> mem_addr_reg == $past(start_addr);
  endproperty
  a_top: assert property (p_top)
    else $error("Frame did not start at start address");

  property p_vblank;
    @(posedge clk) disable iff (!arst_n)
    line_go_reg && scan_line == vb_start |=> vblank_reg;
  endproperty
  a_vblank: assert property (p_vblank)
    else $error("Blank did not start on its line");

  property p_vsync;
    @(posedge clk) disable iff (!arst_n)
    line_go_reg && scan_line == vs_start |=> vsync_reg;
  endproperty
  a_vsync: assert property (p_vsync)
    else $error("Sync did not start on its line");

  property p_resv;
    @(posedge clk) disable iff (!arst_n)
    bus.wr && bus.idx == CSR_IDX |=> cursor_start_reg[7:6] == 2'b00;
  endproperty
  a_resv: assert property (p_resv)
    else $error("Reserved cursor bits were stored");

  property p_read;
    @(posedge clk) disable iff (!arst_n)
    !bus.wr && bus.idx == MSL_IDX
    |=> rd_data_reg == $past(max_scan_line_reg);
  endproperty
  a_read: assert property (p_read)
    else $error("Indexed read returned wrong value");

  property p_curoff;
    @(posedge clk) disable iff (!arst_n)
    !cursor_en |=> !cur_hit_reg;
  endproperty
  a_curoff: assert property (p_curoff)
    else $error("Cursor drawn while off or in graphics");

  property p_curpos;
    @(posedge clk) disable iff (!arst_n)
    cur_hit_reg |-> $past(mem_addr_reg) == $past(cursor_loc)
      && $past(row_scan) >= $past(cursor_start_reg[ROW_W-1:0])
      && $past(row_scan) <= $past(cursor_end_reg[ROW_W-1:0]);
  endproperty
  a_curpos: assert property (p_curpos)
    else $error("Cursor drawn outside its rows or location");

endmodule

// [tb/lcrt_monitor.sv]
// Display monitor model: counts vertical sync pulses it receives.
// Assumes vsync is a registered level from the block on the same clock.
`timescale 1ns/10ps
module lcrt_monitor
(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic vsync,
  output int        vs_count
);
  logic vs_prev_reg;

  // Only rising edges count, so a long pulse is still one frame
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      vs_prev_reg <= 1'b0;
      vs_count    <= 0;
    end
    else
    begin
      vs_prev_reg <= vsync;
      if (vsync && !vs_prev_reg)
        vs_count <= vs_count + 1;
    end
  end
endmodule

// [tb/lcrt_scan_ctrl_bench.sv]
// Self-checking bench for the text scan control block.
// Assumes the block alone with a monitor model on its sync output.
`timescale 1ns/10ps
module lcrt_scan_ctrl_bench
  import lcrt_pkg::*;
;
  logic        clk;
  logic        arst_n;
  lcrt_bus_s   bus;
  lcrt_tick_s  tick;
  logic        text_mode;
  logic [7:0]  rd_data;
  logic [15:0] mem_addr;
  logic [4:0]  row_scan;
  logic [9:0]  scan_line;
  logic        vblank;
  logic        vsync;
  logic        cursor_on;
  int          vs_count;
  int          fail_count;
  int          n_checks;

  lcrt_scan_ctrl uut (
    .clk       (clk),
    .arst_n    (arst_n),
    .bus       (bus),
    .tick      (tick),
    .text_mode (text_mode),
    .rd_data   (rd_data),
    .mem_addr  (mem_addr),
    .row_scan  (row_scan),
    .scan_line (scan_line),
    .vblank    (vblank),
    .vsync     (vsync),
    .cursor_on (cursor_on)
  );

  lcrt_monitor u_mon (
    .clk      (clk),
    .arst_n   (arst_n),
    .vsync    (vsync),
    .vs_count (vs_count)
  );

  initial clk = 1'b0;
  always #20 clk = ~clk;

  task end_sim;
    if (fail_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task wr(input logic [7:0] i, input logic [7:0] d);
    @(negedge clk);
    bus.wr    = 1'b1;
    bus.idx   = i;
    bus.wdata = d;
    @(negedge clk);
    bus.wr = 1'b0;
  endtask

  task rd(input logic [7:0] i, input logic [7:0] e);
    @(negedge clk);
    bus.idx = i;
    @(negedge clk);
    chk({8'h00, rd_data}, {8'h00, e});
  endtask

  // Line strobes are spaced three cycles, above the two-cycle minimum
  task line(input logic f);
    @(negedge clk);
    tick.line_start  = 1'b1;
    tick.frame_start = f;
    @(negedge clk);
    tick.line_start  = 1'b0;
    tick.frame_start = 1'b0;
    @(negedge clk);
  endtask

  task t_regs;
    int i;
    rd(MSL_IDX, 8'h00);
    wr(CSR_IDX, 8'hFF);
    rd(CSR_IDX, 8'h3F);
    wr(CER_IDX, 8'hFF);
    rd(CER_IDX, 8'h7F);
    wr(PRS_IDX, 8'hFF);
    rd(PRS_IDX, 8'h7F);
    wr(8'h20, 8'hA5);
    rd(8'h20, 8'h00);
    for (i = 12; i < 18; i++)
      wr(8'(i), 8'(i) ^ 8'h5A);
    for (i = 12; i < 18; i++)
      rd(8'(i), 8'(i) ^ 8'h5A);
  endtask

  // Split line 0x1C0, blank from 0x203, sync 0x282 to 0x28F
  task t_frame;
    int ln;
    wr(VOF_IDX, 8'h90);
    wr(LCL_IDX, 8'hC0);
    wr(MSL_IDX, 8'h23);
    wr(VBS_IDX, 8'h03);
    wr(VSS_IDX, 8'h82);
    wr(VSE_IDX, 8'h0F);
    wr(PRS_IDX, 8'h02);
    wr(SAH_IDX, 8'h12);
    wr(SAL_IDX, 8'h34);
    for (ln = 0; ln < 656; ln++)
    begin
      line(ln == 0);
      chk(16'(scan_line), 16'(ln));
      chk(16'(row_scan), 16'((2 + ln) % 4));
      chk(16'(vblank), 16'(ln >= 10'h203));
      if (ln >= 10'h27F && ln < 10'h28F)
        chk(16'(vsync), 16'(ln >= 10'h282));
      if (ln == 10'h28F)
        chk(16'(vsync), 16'h0000);
      if (ln == 0 || ln == 10'h1BF)
        chk(mem_addr, 16'h1234);
      if (ln == 10'h1C0)
        chk(mem_addr, 16'h0000);
    end
    chk(16'(vs_count), 16'h0001);
  endtask

  // Other top bits of each value: split 0x210, blank 0x120, sync 0x130
  task t_frame2;
    int ln;
    wr(VOF_IDX, 8'h0C);
    wr(MSL_IDX, 8'h43);
    wr(LCL_IDX, 8'h10);
    wr(VBS_IDX, 8'h20);
    wr(VSS_IDX, 8'h30);
    for (ln = 0; ln < 529; ln++)
    begin
      line(ln == 0);
      chk(16'(vblank), 16'(ln >= 10'h120));
      if (ln >= 10'h12E && ln < 10'h13F)
        chk(16'(vsync), 16'(ln >= 10'h130));
      if (ln == 10'h20F)
        chk(mem_addr, 16'h1234);
      if (ln == 10'h210)
        chk(mem_addr, 16'h0000);
    end
    chk(16'(vs_count), 16'h0002);
  endtask

  task t_dscan;
    int ln;
    wr(MSL_IDX, 8'h83);
    for (ln = 0; ln < 8; ln++)
    begin
      line(ln == 0);
      chk(16'(row_scan), 16'((2 + ln / 2) % 4));
    end
  endtask

  // Ticks every cycle for the first 8 of 16, so each character of skew is one cycle later
  task cur(input logic [7:0] p, input logic [7:0] s, input logic [7:0] e,
           input logic t, output int cnt, output int first);
    int c;
    wr(PRS_IDX, p);
    wr(CSR_IDX, s);
    wr(CER_IDX, e);
    text_mode = t;
    line(1'b1);
    cnt   = 0;
    first = -1;
    for (c = 0; c < 16; c++)
    begin
      @(negedge clk);
      tick.char_tick = (c < 8);
      if (cursor_on === 1'b1)
      begin
        cnt++;
        if (first < 0)
          first = c;
      end
    end
  endtask

  task t_cursor;
    int n;
    int f0;
    int f;
    int k;
    wr(MSL_IDX, 8'h03);
    wr(SAH_IDX, 8'h00);
    wr(SAL_IDX, 8'h40);
    wr(CLH_IDX, 8'h00);
    wr(CLL_IDX, 8'h42);
    cur(8'h02, 8'h01, 8'h02, 1'b1, n, f0);
    chk(16'(n), 16'h0001);
    cur(8'h01, 8'h01, 8'h02, 1'b1, n, f);
    chk(16'(n), 16'h0001);
    cur(8'h00, 8'h01, 8'h02, 1'b1, n, f);
    chk(16'(n), 16'h0000);
    cur(8'h03, 8'h01, 8'h02, 1'b1, n, f);
    chk(16'(n), 16'h0000);
    cur(8'h02, 8'h21, 8'h02, 1'b1, n, f);
    chk(16'(n), 16'h0000);
    cur(8'h02, 8'h01, 8'h02, 1'b0, n, f);
    chk(16'(n), 16'h0000);
    for (k = 1; k < 4; k++)
    begin
      cur(8'h02, 8'h01, 8'h02 | 8'(k << 5), 1'b1, n, f);
      chk(16'(f - f0), 16'(k));
    end
  endtask

  // Reset in mid-run must clear registers and outputs again
  task t_reset;
    @(negedge clk);
    arst_n = 1'b0;
    @(negedge clk);
    arst_n = 1'b1;
    chk(mem_addr, 16'h0000);
    chk(16'(row_scan), 16'h0000);
    chk(16'(cursor_on), 16'h0000);
    rd(CER_IDX, 8'h00);
  endtask

  initial
  begin
    fail_count = 0;
    n_checks   = 0;
    arst_n     = 1'b0;
    bus        = '0;
    tick       = '0;
    text_mode  = 1'b1;
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    t_regs;
    t_frame;
    t_frame2;
    t_dscan;
    t_cursor;
    t_reset;
    end_sim;
  end

  // Tests need about 4000 cycles; this allows some twelve times that
  initial
  begin
    #2000000;
    fail_count++;
    end_sim;
  end
endmodule
